//--- verilog/aoiu_pkg.sv
// Package: constants shared by both ends of the output image link
package aoiu_pkg;
  localparam int WORD_W = 16;
  localparam int CODE_W = 12;
  localparam int DISC_W = 32;
  localparam int NUM_WORDS = 4;
  localparam logic [1:0] WORD_CH0 = 2'h0;
  localparam logic [1:0] WORD_CH1 = 2'h1;
  localparam logic [1:0] WORD_DISC_LO = 2'h2;
  localparam logic [1:0] WORD_DISC_HI = 2'h3;
  localparam logic [11:0] CODE_MAX = 12'hfff;
  localparam int UV_PER_COUNT_X100 = 244;
  localparam int NA_PER_COUNT = 4880;
  localparam logic [31:0] APB_CTRL = 32'h0000_0000;
  localparam logic [31:0] APB_CH0 = 32'h0000_0004;
  localparam logic [31:0] APB_CH1 = 32'h0000_0008;
  localparam logic [31:0] APB_DISC = 32'h0000_000c;
  localparam logic [31:0] APB_STAT = 32'h0000_0010;
  localparam logic [31:0] APB_MASK = 32'h0000_001c;
  localparam logic [2:0] EXP_NONE = 3'h0;
  localparam logic [2:0] EXP_8 = 3'h1;
  localparam logic [2:0] EXP_16 = 3'h2;
  localparam logic [2:0] EXP_24 = 3'h3;
  localparam logic [2:0] EXP_32 = 3'h4;
  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_NEXT} aoiu_state_type;
endpackage : aoiu_pkg

//--- verilog/aoiu_if.sv
// Interface: output image word strobe link between host and device
`timescale 1ns/100ps
interface aoiu_if;
  logic word_valid;
  logic [1:0] word_index;
  logic [15:0] word_data;
  modport host (output word_valid, output word_index, output word_data);
  modport device (input word_valid, input word_index, input word_data);
endinterface : aoiu_if

//--- verilog/aoiu_device.sv
// Device end: unpacks output image words into converter codes and discrete outputs
`timescale 1ns/100ps
module aoiu_device
  import aoiu_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Image link
  aoiu_if.device link,
  // Expansion set size
  input wire logic [2:0] expansion_size,
  // Converter codes
  output logic [11:0] channel0_code,
  output logic [11:0] channel1_code,
  // Discrete expansion outputs
  output logic [31:0] discrete_output_bits
);
  ////////////////////////////////////////////////////////////////////////////
  logic [11:0] next_channel0_code;
  logic [11:0] next_channel1_code;
  logic [31:0] next_discrete_output_bits;
  logic [31:0] disc_mask;

  // Mask of discrete bits that exist for the attached set
  always_comb
  begin
    case (expansion_size)
      EXP_8: disc_mask = 32'h0000_00ff;
      EXP_16: disc_mask = 32'h0000_ffff;
      EXP_24: disc_mask = 32'h00ff_ffff;
      EXP_32: disc_mask = 32'hffff_ffff;
      default: disc_mask = 32'h0000_0000;
    endcase
  end

  // Next values from the written word
  always_comb
  begin
    next_channel0_code = channel0_code;
    next_channel1_code = channel1_code;
    next_discrete_output_bits = discrete_output_bits & disc_mask;
    if (link.word_valid)
    begin
      case (link.word_index)
        WORD_CH0: next_channel0_code = link.word_data[CODE_W-1:0];
        WORD_CH1: next_channel1_code = link.word_data[CODE_W-1:0];
        WORD_DISC_LO: next_discrete_output_bits[15:0] = link.word_data & disc_mask[15:0];
        WORD_DISC_HI: next_discrete_output_bits[31:16] = link.word_data & disc_mask[31:16];
        default: next_channel0_code = channel0_code;
      endcase
    end
  end

  // Registers; codes pass straight to a linear converter
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      channel0_code <= 12'h000;
      channel1_code <= 12'h000;
      discrete_output_bits <= 32'h0000_0000;
    end
    else
    begin
      channel0_code <= next_channel0_code;
      channel1_code <= next_channel1_code;
      discrete_output_bits <= next_discrete_output_bits;
    end
  end
endmodule : aoiu_device

//--- verilog/aoiu_host.sv
// Host end: APB registers for the image, sends words over the link
`timescale 1ns/100ps
module aoiu_host
  import aoiu_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Image link
  aoiu_if.host link,
  // Expansion size to device
  output logic [2:0] expansion_size
);
  ////////////////////////////////////////////////////////////////////////////
  logic [11:0] ch0, ch1;
  logic [31:0] disc;
  logic busy;
  logic [1:0] idx;
  logic [11:0] next_ch0, next_ch1;
  logic [31:0] next_disc;
  logic [2:0] next_size;
  logic next_busy;
  logic [1:0] next_idx;
  logic next_valid;
  logic [15:0] next_data;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, wr, acc;

  // Register, APB and send sequencing
  // A write lands only at the edge where pready is sampled high
  always_comb
  begin
    acc = psel && penable && !pready;
    wr = psel && penable && pready && pwrite;
    next_ch0 = ch0;
    next_ch1 = ch1;
    next_disc = disc;
    next_size = expansion_size;
    next_busy = busy;
    next_idx = idx;
    next_prdata = 32'h0000_0000;
    next_pready = acc;
    next_pslverr = 1'b0;
    next_valid = 1'b0;
    next_data = 16'h0000;
    // Access phase: answer and error flag, ready one cycle later
    if (acc)
    begin
      case (paddr)
        APB_CTRL: next_prdata = {29'h0, expansion_size};
        APB_CH0: next_prdata = {20'h0, ch0};
        APB_CH1: next_prdata = {20'h0, ch1};
        APB_DISC: next_prdata = disc;
        APB_STAT: next_prdata = {31'h0, busy};
        default: next_pslverr = 1'b1;
      endcase
      if (pwrite && paddr == APB_STAT)
        next_pslverr = 1'b1; // Status is read only
    end
    // Completed write; restart the image so the new value is always sent
    if (wr)
    begin
      case (paddr)
        APB_CTRL: next_size = pwdata[2:0];
        APB_CH0: next_ch0 = pwdata[11:0];
        APB_CH1: next_ch1 = pwdata[11:0];
        APB_DISC: next_disc = pwdata;
        default: next_ch0 = ch0;
      endcase
      if (paddr != APB_STAT)
      begin
        next_busy = 1'b1;
        next_idx = 2'h0;
      end
    end
    if (busy && !wr)
    begin
      next_valid = 1'b1;
      case (idx)
        WORD_CH0: next_data = {4'h0, ch0};
        WORD_CH1: next_data = {4'h0, ch1};
        WORD_DISC_LO: next_data = (expansion_size == EXP_8) ? {8'h00, disc[7:0]}
                                                             : disc[15:0];
        default: next_data = (expansion_size == EXP_24) ? {8'h00, disc[23:16]}
                                                          : disc[31:16];
      endcase
      next_idx = idx + 2'h1;
      if (idx == WORD_DISC_HI)
        next_busy = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ch0 <= 12'h000;
      ch1 <= 12'h000;
      disc <= 32'h0000_0000;
      expansion_size <= EXP_NONE;
      busy <= 1'b0;
      idx <= 2'h0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      link.word_valid <= 1'b0;
      link.word_data <= 16'h0000;
      link.word_index <= 2'h0;
    end
    else
    begin
      ch0 <= next_ch0;
      ch1 <= next_ch1;
      disc <= next_disc;
      expansion_size <= next_size;
      busy <= next_busy;
      idx <= next_idx;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      link.word_valid <= next_valid;
      link.word_data <= next_data;
      link.word_index <= idx;
    end
  end
endmodule : aoiu_host

//--- verif/aoiu_checker.sv
// Checker: link words against unpacked device outputs
`timescale 1ns/100ps
module aoiu_checker
  import aoiu_pkg::*;
(
  // Link and device signals
  input wire logic clk,
  input wire logic reset,
  input wire logic word_valid,
  input wire logic [1:0] word_index,
  input wire logic [15:0] word_data,
  input wire logic [2:0] expansion_size,
  input wire logic [11:0] channel0_code,
  input wire logic [11:0] channel1_code,
  input wire logic [31:0] discrete_output_bits
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Strobe of one image word
  sequence s_w(logic [1:0] i);
    word_valid && word_index == i;
  endsequence
  AST_CH0: assert property (s_w(WORD_CH0)
    |=> channel0_code == $past(word_data[11:0])) else $error("ch0 code wrong");
  AST_CH1: assert property (s_w(WORD_CH1)
    |=> channel1_code == $past(word_data[11:0])) else $error("ch1 code wrong");
  AST_D8: assert property (s_w(WORD_DISC_LO) ##0 expansion_size == EXP_8
    |=> discrete_output_bits[7:0] == $past(word_data[7:0])) else $error("d8 wrong");
  AST_HI8: assert property (expansion_size == EXP_8
    |=> discrete_output_bits[31:8] == 24'h0) else $error("d8 upper not clear");
  AST_D16: assert property (s_w(WORD_DISC_LO) ##0 expansion_size == EXP_16
    |=> discrete_output_bits[15:0] == $past(word_data)) else $error("d16 wrong");
  AST_D24: assert property (s_w(WORD_DISC_HI) ##0 expansion_size == EXP_24
    |=> discrete_output_bits[23:16] == $past(word_data[7:0])) else $error("d24 wrong");
  AST_D32: assert property (s_w(WORD_DISC_HI) ##0 expansion_size == EXP_32
    |=> discrete_output_bits[31:16] == $past(word_data)) else $error("d32 wrong");
  AST_NONE: assert property (expansion_size == EXP_NONE
    |=> discrete_output_bits == 32'h0) else $error("outputs without expansion");
endmodule : aoiu_checker

//--- verif/aoiu_test.sv
// Testbench: APB image writes through host and device
`timescale 1ns/100ps
module aoiu_test
  import aoiu_pkg::*;
;
  logic clk = 1'h0, reset = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e;
  logic [2:0] expansion_size;
  logic [11:0] channel0_code, channel1_code;
  logic [31:0] discrete_output_bits;
  int error_cnt = 0, compares = 0, cyc = 0;
  localparam logic [31:0] MSK [5] = '{32'h0, 32'hff, 32'hffff, 32'hff_ffff, 32'hffff_ffff};
  aoiu_if link ();
  aoiu_host aoiu_host_inst (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .link(link), .expansion_size);
  aoiu_device aoiu_device_inst (.clk, .reset, .link(link), .expansion_size,
    .channel0_code, .channel1_code, .discrete_output_bits);
  aoiu_checker aoiu_checker_inst (.clk, .reset, .word_valid(link.word_valid),
    .word_index(link.word_index), .word_data(link.word_data), .expansion_size,
    .channel0_code, .channel1_code, .discrete_output_bits);
  // Clock and cycle ceiling
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 1000)
    begin
      error_cnt++;
      results();
    end
  end
  //////////////////////////////////////////////////////////////////
  // Compare and report
  task chk(input logic [31:0] g, x);
    compares++;
    if (g !== x)
      $display("MISMATCH %0t got %h exp %h", $time, g, x);
    if (g !== x)
      error_cnt++;
  endtask : chk
  // One APB transfer, held until pready
  task apb(input logic [31:0] a, d, input logic w);
    @(posedge clk);
    psel <= 1'h1;
    paddr <= a;
    pwdata <= d;
    pwrite <= w;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1)
      @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task results;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  // Every expansion size, shrinking, with junk in unused bits
  initial
  begin
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    chk(discrete_output_bits, 32'h0);
    for (int s = 4; s >= 0; s--)
    begin
      apb(APB_CTRL, s, 1'h1);
      apb(APB_CH0, 32'hffff_f000 | (s * 32'h333), 1'h1);
      apb(APB_CH1, {20'hfffff, CODE_MAX}, 1'h1);
      apb(APB_DISC, 32'ha5c3_96e1, 1'h1);
      repeat (6) @(posedge clk);
      chk({20'h0, channel0_code}, s * 32'h333);
      chk({20'h0, channel1_code}, {20'h0, CODE_MAX});
      chk(discrete_output_bits, 32'ha5c3_96e1 & MSK[s]);
    end
    apb(32'h14, 32'h0, 1'h0);
    chk({31'h0, e}, 32'h1);
    apb(APB_STAT, 32'h0, 1'h0);
    chk(q, 32'h0);
    results();
  end
endmodule : aoiu_test
